// File: serial_adc_device.sv
// Converter sequencer and framed serial port of the device end
// Functional notes
// - Role pin low: drive clock and frame
// - Role pin high: host supplies clock, frame
// - Start edge holds and converts when settled
// - Start during settling waits for its end
// - Conversion timed by master clock
// - Master bit clock divided from master clock
// - Slave: host clock shifts both directions
// - Control bits follow low transmit frame
// - Slave host strobes receive frame low
// - Master drives active-low receive frame
// - Host may tie both frame lines
// - Frame: zero, channel, twelve result bits
// - Sixteen bits valid at falling edges
// - Bipolar two's complement, unipolar binary
// - First five falling edges load control
// - Later data bits ignored in frame
// - Channel chosen by control select bits
module serial_adc_device #(
  parameter bit BIPOLAR = 1'b0,
  parameter int SETTLE_CYCLES = serial_adc_pkg::SETTLE_CYCLES_DEF
) (
  // Master clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Pins and converter core
  input  wire logic        convert_start_in_i,
  input  wire logic        serial_role_select_i,
  input  wire logic [11:0] sample_code_i,
  // Status towards the analog side
  output logic             track_hold_o,
  output logic [2:0]       channel_select_o,
  output logic             busy_o,
  // Serial link
  serial_adc_link_if.device link
);

  typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_CONVERT} conv_state_t;

  localparam logic [15:0] SETTLE_LEN = 16'(SETTLE_CYCLES);
  localparam logic [7:0]  CONV_LAST = 8'(serial_adc_pkg::CONV_CYCLES - 1);
  localparam logic [3:0]  HALF_LAST = 4'(serial_adc_pkg::SCLK_HALF - 1);
  localparam logic [3:0]  HALF_MID = 4'(serial_adc_pkg::SCLK_HALF / 2 - 1);
  localparam logic [4:0]  NBITS = 5'(serial_adc_pkg::FRAME_BITS);
  localparam logic [2:0]  NCTRL = 3'(serial_adc_pkg::CTRL_BITS);
  localparam logic [2:0]  GAP_LEN = 3'(serial_adc_pkg::FRAME_GAP);
  localparam logic [6:0]  LRST_LEN = 7'(serial_adc_pkg::LINK_RST_CYCLES);

  // Master clock domain
  logic [1:0]  conv_sync_q;
  logic        conv_prev_q;
  logic [1:0]  role_sync_q;
  logic        master_q;
  logic [1:0]  ctl_sync_q;
  logic        ctl_seen_q;
  logic [4:0]  ctrl_q;
  logic [15:0] settle_q;
  logic [7:0]  conv_cnt_q;
  logic [11:0] sample_q;
  conv_state_t state_q;
  logic        hold_q;
  logic [15:0] result_q;
  logic        res_tgl_q;
  logic [3:0]  div_q;
  logic        sclk_q;
  logic        pend_q;
  logic [2:0]  gap_q;
  logic        rfs_q;
  logic        frame_q;
  logic [4:0]  fr_cnt_q;
  logic [6:0]  lrst_cnt_q;
  logic        lrst_q;

  // Link clock domain
  logic [1:0]  rst_l_q;
  logic [1:0]  res_sync_q;
  logic        res_seen_q;
  logic [15:0] tx_word_q;
  logic [15:0] tx_sh_q;
  logic [4:0]  tx_cnt_q;
  logic        dout_q;
  logic        dout_oe_q;
  logic [4:0]  ctl_sh_q;
  logic [2:0]  ctl_cnt_q;
  logic [4:0]  ctl_word_q;
  logic        ctl_tgl_q;

  logic conv_rise;
  logic ctrl_load;
  logic start_req;
  logic settling;
  logic rise_ev;
  logic fall_ev;
  logic mid_low;
  logic rst_link;

  assign conv_rise = conv_sync_q[1] & ~conv_prev_q;
  assign ctrl_load = ctl_sync_q[1] ^ ctl_seen_q;
  assign start_req = (conv_rise | (ctrl_load & ctl_word_q[serial_adc_pkg::CTRL_SWCONV]))
                     & ~ctrl_q[serial_adc_pkg::CTRL_STANDBY];
  assign settling = (settle_q != 16'h0000) | ctrl_load;
  assign rise_ev = (div_q == HALF_LAST) & ~sclk_q;
  assign fall_ev = (div_q == HALF_LAST) & sclk_q;
  assign mid_low = (div_q == HALF_MID) & ~sclk_q;
  assign rst_link = rst_l_q[1];

  // Pin synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_sync_q <= 2'h0;
      conv_prev_q <= 1'b0;
      role_sync_q <= 2'h0;
      master_q    <= 1'b0;
    end
    else
    begin
      conv_sync_q <= {conv_sync_q[0], convert_start_in_i};
      conv_prev_q <= conv_sync_q[1];
      role_sync_q <= {role_sync_q[0], serial_role_select_i};
      master_q    <= ~role_sync_q[1];
    end
  end

  // Control word taken over from the link side; stable once its toggle is seen
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_sync_q <= 2'h0;
      ctl_seen_q <= 1'b0;
      ctrl_q     <= serial_adc_pkg::CTRL_RST;
    end
    else
    begin
      ctl_sync_q <= {ctl_sync_q[0], ctl_tgl_q};
      ctl_seen_q <= ctl_sync_q[1];
      if (ctrl_load)
        ctrl_q <= ctl_word_q;
    end
  end

  // Settling pulse restarts on every control load, as a new channel needs time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      settle_q <= 16'h0000;
    else if (ctrl_load)
      settle_q <= SETTLE_LEN;
    else if (settle_q != 16'h0000)
      settle_q <= settle_q - 16'h0001;
  end

  // Conversion sequencer; starts during a conversion are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q    <= S_IDLE;
      hold_q     <= 1'b0;
      conv_cnt_q <= 8'h00;
      sample_q   <= 12'h000;
      result_q   <= 16'h0000;
      res_tgl_q  <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if (start_req && !settling)
          begin
            state_q    <= S_CONVERT;
            hold_q     <= 1'b1;
            conv_cnt_q <= 8'h00;
            sample_q   <= sample_code_i;
          end
          else if (start_req)
            state_q <= S_SETTLE;
        end
        S_SETTLE:
        begin
          if (!settling)
          begin
            state_q    <= S_CONVERT;
            hold_q     <= 1'b1;
            conv_cnt_q <= 8'h00;
            sample_q   <= sample_code_i;
          end
        end
        S_CONVERT:
        begin
          conv_cnt_q <= conv_cnt_q + 8'h01;
          if (conv_cnt_q == CONV_LAST)
          begin
            state_q   <= S_IDLE;
            hold_q    <= 1'b0;
            result_q  <= {1'b0, ctrl_q[serial_adc_pkg::CTRL_CH_MSB:serial_adc_pkg::CTRL_CH_LSB],
                          serial_adc_pkg::fmt_code(sample_q, BIPOLAR)};
            res_tgl_q <= ~res_tgl_q;
          end
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // Bit clock divider, free running in both roles; drives the link only while the role pin is low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q  <= 4'h0;
      sclk_q <= 1'b0;
    end
    else if (div_q == HALF_LAST)
    begin
      div_q  <= 4'h0;
      sclk_q <= ~sclk_q;
    end
    else
      div_q <= div_q + 4'h1;
  end

  // Master frame; gap lets the result cross into the link domain first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_q   <= 1'b0;
      gap_q    <= 3'h0;
      rfs_q    <= 1'b1;
      frame_q  <= 1'b0;
      fr_cnt_q <= 5'h00;
    end
    else
    begin
      if (state_q == S_CONVERT && conv_cnt_q == CONV_LAST && master_q)
      begin
        pend_q <= 1'b1;
        gap_q  <= GAP_LEN;
      end
      else if (!master_q)
        pend_q <= 1'b0;
      else if (fall_ev && gap_q != 3'h0)
        gap_q <= gap_q - 3'h1;
      else if (mid_low && pend_q && !frame_q && gap_q == 3'h0)
      begin
        pend_q   <= 1'b0;
        frame_q  <= 1'b1;
        rfs_q    <= 1'b0;
        fr_cnt_q <= 5'h00;
      end
      if (frame_q && fall_ev && fr_cnt_q != NBITS)
        fr_cnt_q <= fr_cnt_q + 5'h01;
      if (frame_q && mid_low && fr_cnt_q == NBITS)
      begin
        frame_q <= 1'b0;
        rfs_q   <= 1'b1;
      end
    end
  end

  // Bit clock stands still in reset, so the link reset outlasts it
  // Limitation: needs a running bit clock within the stretch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lrst_cnt_q <= LRST_LEN;
      lrst_q     <= 1'b1;
    end
    else if (lrst_cnt_q != 7'h00)
      lrst_cnt_q <= lrst_cnt_q - 7'h01;
    else
      lrst_q <= 1'b0;
  end

  // Link side reset, released on the link clock
  always_ff @(posedge link.sclk)
    rst_l_q <= {rst_l_q[0], lrst_q};

  // Output shifter: bit changes on rising edges, valid at the falling ones
  always_ff @(posedge link.sclk)
  begin
    if (rst_link)
    begin
      res_sync_q <= 2'h0;
      res_seen_q <= 1'b0;
      tx_word_q  <= 16'h0000;
      tx_sh_q    <= 16'h0000;
      tx_cnt_q   <= 5'h00;
      dout_q     <= 1'b0;
      dout_oe_q  <= 1'b0;
    end
    else
    begin
      res_sync_q <= {res_sync_q[0], res_tgl_q};
      if (link.receive_frame_sync_n)
      begin
        tx_cnt_q  <= 5'h00;
        dout_oe_q <= 1'b0;
        if (res_sync_q[1] != res_seen_q)
        begin
          res_seen_q <= res_sync_q[1];
          tx_word_q  <= result_q;
          tx_sh_q    <= result_q;
        end
        else
          tx_sh_q <= tx_word_q;
      end
      else if (tx_cnt_q != NBITS)
      begin
        dout_q    <= tx_sh_q[15];
        tx_sh_q   <= {tx_sh_q[14:0], 1'b0};
        dout_oe_q <= 1'b1;
        tx_cnt_q  <= tx_cnt_q + 5'h01;
      end
      else
        dout_oe_q <= 1'b0;
    end
  end

  // Control shifter on falling edges after the transmit frame falls
  always_ff @(negedge link.sclk)
  begin
    if (rst_link)
    begin
      ctl_sh_q   <= 5'h00;
      ctl_cnt_q  <= 3'h0;
      ctl_word_q <= serial_adc_pkg::CTRL_RST;
      ctl_tgl_q  <= 1'b0;
    end
    else if (link.transmit_frame_sync_n)
      ctl_cnt_q <= 3'h0;
    else if (ctl_cnt_q != NCTRL)
    begin
      ctl_sh_q  <= {ctl_sh_q[3:0], link.data_in};
      ctl_cnt_q <= ctl_cnt_q + 3'h1;
      if (ctl_cnt_q == NCTRL - 3'h1)
      begin
        ctl_word_q <= {ctl_sh_q[3:0], link.data_in};
        ctl_tgl_q  <= ~ctl_tgl_q;
      end
    end
    // Counter parked at five: later bits fall through untouched
  end

  assign track_hold_o = hold_q;
  assign channel_select_o = ctrl_q[serial_adc_pkg::CTRL_CH_MSB:serial_adc_pkg::CTRL_CH_LSB];
  assign busy_o = hold_q;
  assign link.dev_sclk_o = sclk_q;
  assign link.dev_sclk_oe = master_q;
  assign link.dev_rfs_n_o = rfs_q;
  assign link.dev_rfs_oe = master_q;
  assign link.dev_dout_o = dout_q;
  assign link.dev_dout_oe = dout_oe_q;

endmodule

// File: serial_adc_host.sv
// Host serial port controller with a Wishbone register slave
module serial_adc_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [3:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        stb_i,
  input  wire logic        cyc_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Serial link
  serial_adc_link_if.host  link
);

  typedef enum logic {H_IDLE, H_RUN} host_state_t;

  localparam logic [3:0] HALF_LAST = 4'(serial_adc_pkg::SCLK_HALF - 1);
  localparam logic [3:0] HALF_MID = 4'(serial_adc_pkg::SCLK_HALF / 2 - 1);
  localparam logic [4:0] NBITS = 5'(serial_adc_pkg::FRAME_BITS);
  localparam logic [4:0] NCTRL = 5'(serial_adc_pkg::CTRL_BITS);

  logic [4:0]  cmd_q;
  logic        go_q;
  logic        slave_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [15:0] result_q;
  logic        valid_q;
  logic [3:0]  div_q;
  logic        sclk_q;
  logic [1:0]  sck_s_q;
  logic        sck_p_q;
  logic [1:0]  dat_s_q;
  logic [1:0]  rfs_s_q;
  host_state_t state_q;
  logic        tfs_q;
  logic        rfs_q;
  logic        din_q;
  logic [4:0]  tx_sh_q;
  logic [4:0]  fr_cnt_q;
  logic [15:0] rx_sh_q;
  logic [4:0]  rx_cnt_q;

  logic req;
  logic wr;
  logic rd_result;
  logic div_rise;
  logic div_fall;
  logic mid_low;
  logic sync_fall;
  logic rx_active;
  logic rx_ev;

  assign req = cyc_i & stb_i & ~ack_q;
  assign wr = req & we_i & sel_i[0];
  assign rd_result = req & ~we_i & (adr_i == serial_adc_pkg::REG_RESULT);
  assign div_rise = (div_q == HALF_LAST) & ~sclk_q;
  assign div_fall = (div_q == HALF_LAST) & sclk_q;
  assign mid_low = (div_q == HALF_MID) & ~sclk_q;
  assign sync_fall = sck_p_q & ~sck_s_q[1];
  assign rx_active = slave_q ? (state_q == H_RUN) : ~rfs_s_q[1];
  assign rx_ev = slave_q ? div_fall : sync_fall;

  // Register slave: ack one cycle after the request, dropped the next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q   <= 1'b0;
      dat_q   <= 32'h0000_0000;
      cmd_q   <= serial_adc_pkg::CTRL_RST;
      slave_q <= serial_adc_pkg::MODE_RST;
    end
    else
    begin
      ack_q <= req;
      if (wr && adr_i == serial_adc_pkg::REG_CMD)
        cmd_q <= dat_i[4:0];
      if (wr && adr_i == serial_adc_pkg::REG_MODE && state_q == H_IDLE)
        slave_q <= dat_i[serial_adc_pkg::MODE_SLAVE];
      if (req && !we_i)
      begin
        case (adr_i)
          serial_adc_pkg::REG_CMD:    dat_q <= {27'h0, cmd_q};
          serial_adc_pkg::REG_STATUS: dat_q <= {30'h0, valid_q, go_q | (state_q == H_RUN)};
          serial_adc_pkg::REG_RESULT: dat_q <= {16'h0, result_q};
          serial_adc_pkg::REG_MODE:   dat_q <= {31'h0, slave_q};
          default:                    dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Bit clock divider and pin synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q   <= 4'h0;
      sclk_q  <= 1'b0;
      sck_s_q <= 2'h0;
      sck_p_q <= 1'b0;
      dat_s_q <= 2'h0;
      rfs_s_q <= 2'h3;
    end
    else
    begin
      div_q   <= (div_q == HALF_LAST) ? 4'h0 : div_q + 4'h1;
      if (div_q == HALF_LAST)
        sclk_q <= ~sclk_q;
      sck_s_q <= {sck_s_q[0], link.sclk};
      sck_p_q <= sck_s_q[1];
      dat_s_q <= {dat_s_q[0], link.data_out};
      rfs_s_q <= {rfs_s_q[0], link.receive_frame_sync_n};
    end
  end

  // Transmit frame; in slave role both frame lines move together
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      go_q     <= 1'b0;
      state_q  <= H_IDLE;
      tfs_q    <= 1'b1;
      rfs_q    <= 1'b1;
      din_q    <= 1'b0;
      tx_sh_q  <= 5'h00;
      fr_cnt_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        H_IDLE:
        begin
          if (go_q && (slave_q ? mid_low : sync_fall))
          begin
            go_q     <= 1'b0;
            state_q  <= H_RUN;
            tfs_q    <= 1'b0;
            rfs_q    <= ~slave_q;
            din_q    <= cmd_q[4];
            tx_sh_q  <= {cmd_q[3:0], 1'b0};
            fr_cnt_q <= 5'h00;
          end
        end
        H_RUN:
        begin
          if (rx_ev && fr_cnt_q != NBITS)
            fr_cnt_q <= fr_cnt_q + 5'h01;
          if ((slave_q ? (div_rise && fr_cnt_q != 5'h00) : sync_fall))
          begin
            din_q   <= tx_sh_q[4];
            tx_sh_q <= {tx_sh_q[3:0], 1'b0};
          end
          if ((slave_q && mid_low && fr_cnt_q == NBITS) ||
              (!slave_q && sync_fall && fr_cnt_q == NCTRL - 5'h01))
          begin
            state_q <= H_IDLE;
            tfs_q   <= 1'b1;
            rfs_q   <= 1'b1;
          end
        end
        default:
          state_q <= H_IDLE;
      endcase
      // A new command written now is kept, set wins
      if (wr && adr_i == serial_adc_pkg::REG_CMD)
        go_q <= 1'b1;
    end
  end

  // Receive shifter; valid is set over a same-cycle read clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_sh_q  <= 16'h0000;
      rx_cnt_q <= 5'h00;
      result_q <= 16'h0000;
      valid_q  <= 1'b0;
    end
    else
    begin
      if (rd_result)
        valid_q <= 1'b0;
      if (!rx_active)
        rx_cnt_q <= 5'h00;
      else if (rx_ev && rx_cnt_q != NBITS)
      begin
        rx_sh_q  <= {rx_sh_q[14:0], dat_s_q[1]};
        rx_cnt_q <= rx_cnt_q + 5'h01;
        if (rx_cnt_q == NBITS - 5'h01)
        begin
          result_q <= {rx_sh_q[14:0], dat_s_q[1]};
          valid_q  <= 1'b1;
        end
      end
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign link.host_sclk_o = sclk_q;
  assign link.host_sclk_oe = slave_q;
  assign link.host_rfs_n_o = rfs_q;
  assign link.host_rfs_oe = slave_q;
  assign link.transmit_frame_sync_n = tfs_q;
  assign link.data_in = din_q;

endmodule

// File: serial_adc_link_if.sv
// Serial link between the converter port and its host controller
interface serial_adc_link_if;
  logic dev_sclk_o;
  logic dev_sclk_oe;
  logic host_sclk_o;
  logic host_sclk_oe;
  logic sclk;
  logic dev_rfs_n_o;
  logic dev_rfs_oe;
  logic host_rfs_n_o;
  logic host_rfs_oe;
  logic receive_frame_sync_n;
  logic transmit_frame_sync_n;
  logic data_in;
  logic dev_dout_o;
  logic dev_dout_oe;
  logic data_out;

  // Wire resolution; undriven lines idle high
  assign sclk = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe ? host_sclk_o : 1'b1);
  assign receive_frame_sync_n = dev_rfs_oe ? dev_rfs_n_o : (host_rfs_oe ? host_rfs_n_o : 1'b1);
  assign data_out = dev_dout_oe ? dev_dout_o : 1'b1;

  modport device (
    output dev_sclk_o, dev_sclk_oe, dev_rfs_n_o, dev_rfs_oe, dev_dout_o, dev_dout_oe,
    input  sclk, receive_frame_sync_n, transmit_frame_sync_n, data_in
  );
  modport host (
    output host_sclk_o, host_sclk_oe, host_rfs_n_o, host_rfs_oe, transmit_frame_sync_n, data_in,
    input  sclk, receive_frame_sync_n, data_out
  );
endinterface

// File: serial_adc_monitor.sv
// Link protocol checker between the converter port and its host
module serial_adc_monitor (
  // Clocks and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sclk,
  // Link lines
  input  wire logic dev_sclk_oe,
  input  wire logic host_sclk_oe,
  input  wire logic dev_rfs_oe,
  input  wire logic host_rfs_oe,
  input  wire logic receive_frame_sync_n,
  input  wire logic dev_dout_oe,
  input  wire logic data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  sequence s_eight_bits;
    dev_dout_oe [*8];
  endsequence

  // Output stays driven for exactly sixteen falling edges
  sequence s_full_frame;
    s_eight_bits ##1 s_eight_bits ##1 !dev_dout_oe;
  endsequence

  a_role_drives_both: assert property (
    @(posedge clk_i) disable iff (rst_i) dev_sclk_oe == dev_rfs_oe)
    else $error("clock and frame drive differ");
  a_one_clock_driver: assert property (
    @(posedge clk_i) disable iff (rst_i) !(dev_sclk_oe && host_sclk_oe))
    else $error("two drivers on bit clock");
  a_one_frame_driver: assert property (
    @(posedge clk_i) disable iff (rst_i) !(dev_rfs_oe && host_rfs_oe))
    else $error("two drivers on receive frame");
  a_lead_bit_zero: assert property (
    @(negedge sclk) disable iff (rst_i) $rose(dev_dout_oe) |-> !data_out)
    else $error("first frame bit not zero");
  a_sixteen_bits_out: assert property (
    @(negedge sclk) disable iff (rst_i) $rose(dev_dout_oe) |-> s_full_frame)
    else $error("frame length not sixteen");
  a_frame_covers_data: assert property (
    @(negedge sclk) disable iff (rst_i) dev_dout_oe |-> !receive_frame_sync_n)
    else $error("data driven outside frame");
  a_master_clock_half: assert property (
    @(posedge clk_i) disable iff (rst_i)
    dev_sclk_oe && $rose(sclk) |-> (sclk || !dev_sclk_oe) [*8] ##1 (!sclk || !dev_sclk_oe))
    else $error("bit clock high phase wrong");
  a_data_stable_low: assert property (
    @(posedge clk_i) disable iff (rst_i)
    dev_dout_oe && !sclk && !$past(sclk) |-> $stable(data_out))
    else $error("data moved in low phase");
endmodule

// File: serial_adc_pkg.sv
// Shared constants for the serial converter port and its controller
package serial_adc_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_CONVERT_NS = 5900;
  // Longest time, so rounded down to whole cycles
  localparam int CONV_CYCLES = T_CONVERT_NS / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES_DEF = 64;
  localparam int SCLK_HALF = 8;
  localparam int FRAME_GAP = 4;
  // Link side reset is stretched so that the bit clock can clock it in
  localparam int LINK_RST_CYCLES = 64;

  // Frame and control word geometry
  localparam int FRAME_BITS = 16;
  localparam int CTRL_BITS = 5;
  localparam int CODE_BITS = 12;
  localparam int CH_BITS = 3;

  // Control word fields, first bit shifted in lands in bit 4
  localparam int CTRL_CH_MSB = 4;
  localparam int CTRL_CH_LSB = 2;
  localparam int CTRL_SWCONV = 1;
  localparam int CTRL_STANDBY = 0;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // Controller register map, byte offsets
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam logic [3:0] REG_MODE = 4'hC;
  localparam int STAT_BUSY = 0;
  localparam int STAT_VALID = 1;
  localparam int MODE_SLAVE = 0;
  localparam logic MODE_RST = 1'b0;

  // Core code is straight binary; bipolar range reports two's complement
  function automatic logic [11:0] fmt_code(input logic [11:0] raw, input logic bipolar);
    fmt_code = bipolar ? {~raw[11], raw[10:0]} : raw;
  endfunction

endpackage

// File: serial_adc_port_control_tb.sv
// Testbench joining the converter port and its host controller
module serial_adc_port_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i;
  logic        rst_i;
  logic        cs;
  logic        role;
  logic [11:0] code;
  logic [3:0]  adr;
  logic [31:0] wdat;
  logic [3:0]  sel;
  logic        we;
  logic        stb;
  logic        cyc;
  logic [31:0] rdat;
  logic        ack;
  logic        th;
  logic [2:0]  chan;
  logic        busy;
  logic [31:0] q;
  int          wn;
  int          hn;
  int          cycles = 0;
  int          errors = 0;
  int          checks_done = 0;

  serial_adc_link_if link ();

  serial_adc_device #(.BIPOLAR(1'b0), .SETTLE_CYCLES(40)) u_serial_adc_device (
    .clk_i(clk_i), .rst_i(rst_i), .convert_start_in_i(cs), .serial_role_select_i(role),
    .sample_code_i(code), .track_hold_o(th), .channel_select_o(chan), .busy_o(busy), .link(link));
  serial_adc_host u_serial_adc_host (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .we_i(we),
    .stb_i(stb), .cyc_i(cyc), .dat_o(rdat), .ack_o(ack), .link(link));
  serial_adc_monitor u_serial_adc_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk), .dev_sclk_oe(link.dev_sclk_oe),
    .host_sclk_oe(link.host_sclk_oe), .dev_rfs_oe(link.dev_rfs_oe), .host_rfs_oe(link.host_rfs_oe),
    .receive_frame_sync_n(link.receive_frame_sync_n), .dev_dout_oe(link.dev_dout_oe),
    .data_out(link.data_out));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Whole run needs a few thousand cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    r = rdat;
    chk("bus answer", 32'(ack), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, serial_adc_pkg::REG_STATUS, 32'h0, r);
      n++;
    end
    while (r[b] !== v && n < 300);
    chk("status poll", 32'(r[b]), 32'(v));
  endtask

  // Start pin held until hold begins, then hold length counted
  task automatic convert(input logic [11:0] c, output int w, output int h);
    code <= c;
    cs <= 1'b1;
    w = 0;
    h = 0;
    while (th !== 1'b1 && w < 100)
    begin
      @(posedge clk_i);
      w++;
    end
    cs <= 1'b0;
    chk("busy", 32'(busy), 32'h1);
    while (th === 1'b1 && h < 300)
    begin
      @(posedge clk_i);
      h++;
    end
    repeat (4) @(posedge clk_i);
  endtask

  task automatic read_result(input logic [31:0] exp);
    wb(1'b0, serial_adc_pkg::REG_RESULT, 32'h0, q);
    chk("result", q, exp);
  endtask

  initial
  begin
    rst_i = 1'b1;
    cs = 1'b0;
    role = 1'b0;
    code = 12'h000;
    adr = 4'h0;
    wdat = 32'h0;
    sel = 4'h0;
    we = 1'b0;
    stb = 1'b0;
    cyc = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, 4'h2, 32'hFF, q);
    wb(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", q, 32'h0);
    // Device link side is still in its stretched reset
    repeat (100) @(posedge clk_i);
    wb(1'b1, serial_adc_pkg::REG_CMD, 32'h14, q);
    poll(serial_adc_pkg::STAT_BUSY, 1'b0);
    chk("channel", 32'(chan), 32'h5);
    convert(12'hA5C, wn, hn);
    chk("settle wait", 32'(wn > 8), 32'h1);
    chk("convert time", 32'(hn >= 145 && hn <= 149), 32'h1);
    poll(serial_adc_pkg::STAT_VALID, 1'b1);
    read_result(32'h5A5C);
    wb(1'b0, serial_adc_pkg::REG_STATUS, 32'h0, q);
    chk("valid clear", 32'(q[serial_adc_pkg::STAT_VALID]), 32'h0);
    convert(12'h0FF, wn, hn);
    chk("settled start", 32'(wn <= 6), 32'h1);
    poll(serial_adc_pkg::STAT_VALID, 1'b1);
    read_result(32'h50FF);
    role <= 1'b1;
    repeat (5) @(posedge clk_i);
    wb(1'b1, serial_adc_pkg::REG_MODE, 32'h1, q);
    wb(1'b0, serial_adc_pkg::REG_MODE, 32'h0, q);
    chk("mode", q, 32'h1);
    wb(1'b1, serial_adc_pkg::REG_CMD, 32'h08, q);
    poll(serial_adc_pkg::STAT_BUSY, 1'b0);
    read_result(32'h50FF);
    chk("channel", 32'(chan), 32'h2);
    convert(12'h123, wn, hn);
    // Result needs a few bit clocks to reach the output register
    repeat (64) @(posedge clk_i);
    wb(1'b1, serial_adc_pkg::REG_CMD, 32'h08, q);
    poll(serial_adc_pkg::STAT_BUSY, 1'b0);
    read_result(32'h2123);
    report_and_stop();
  end
endmodule
